// ---- src/bfb_pkg.sv ----
// constants, types and decode function for the flash bank bus glue
package bfb_pkg;

    // ------------------------------------------------------------
    // widths and fields
    // ------------------------------------------------------------
    localparam int        LANES     = 4;
    localparam int        DATA_W    = 32;
    localparam int        WORD_AW   = 30;
    localparam int        FLASH_AW  = 20;
    localparam int        DEC_W     = WORD_AW - FLASH_AW;
    localparam logic [DEC_W-1:0] BANK_BASE = 10'h000;
    localparam logic [LANES-1:0] LANES_OFF = 4'hf;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ANTIC   = 3'h1,
        ST_RD_GATE = 3'h3,
        ST_RD_RDY  = 3'h2,
        ST_WR_STB  = 3'h6,
        ST_WR_HOLD = 3'h7,
        ST_WR_RDY  = 3'h5
    } bfb_state_t;

    typedef struct packed {
        logic                ads_n;
        logic                wr;
        logic [WORD_AW-1:0]  addr;
        logic [LANES-1:0]    be_n;
    } bfb_req_t;

    typedef struct packed {
        logic [LANES-1:0]    ce_n;
        logic                oe_n;
        logic                we_n;
        logic [FLASH_AW-1:0] addr;
    } bfb_pins_t;

    localparam bfb_pins_t PINS_IDLE = '{ce_n: 4'hf, oe_n: 1'b1, we_n: 1'b1, addr: 20'h00000};

    // bank hit: upper word address bits match and at least one lane enabled
    function automatic logic bfb_hit(input bfb_req_t r, input logic [DEC_W-1:0] base);
        return (r.addr[WORD_AW-1:FLASH_AW] == base) && (r.be_n != LANES_OFF);
    endfunction

endpackage

// ---- src/bfb_ctrl.sv ----
// bus glue driving a bank of four byte-wide flash devices
// ------------------------------------------------------------
// Summary of operation
// - output gate asserted only for reads
// - writes only by pulsing write strobe low
// - hold address and data until strobe rises
// - four byte devices, one per lane
// - word address 21..2 to all devices
// - word address bus, lanes by enables
// - select lost mid-cycle returns to idle
// - read: gate T2, ready T3, release T4
// - write: strobe T2 to T4, ready T4 for one clock, release T5
// ------------------------------------------------------------
module bfb_ctrl
    import bfb_pkg::*;
#(
    parameter logic [bfb_pkg::DEC_W-1:0] BASE = bfb_pkg::BANK_BASE
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire bfb_pkg::bfb_req_t          cpu_req,
    input  wire logic [bfb_pkg::DATA_W-1:0] cpu_wdata,
    output logic      [bfb_pkg::DATA_W-1:0] cpu_rdata,
    output logic                            cpu_rdy_n,
    output bfb_pkg::bfb_pins_t              flash,
    input  wire logic [bfb_pkg::DATA_W-1:0] flash_dq_in,
    output logic      [bfb_pkg::DATA_W-1:0] flash_dq_out,
    output logic                            flash_dq_oe_n,
    output logic                            powerdown_reset_n
);
    import bfb_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bfb_state_t              state;
    bfb_state_t              next_state;
    bfb_pins_t               next_flash;
    logic [DATA_W-1:0]       next_rdata;
    logic [DATA_W-1:0]       next_dq_out;
    logic                    next_dq_oe_n;
    logic                    next_rdy_n;
    logic                    cs;

    // live decode, sampled every clock so a lost select aborts at once
    // lanes by enables, not address
    assign cs = bfb_hit(cpu_req, BASE);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_state   = state;
        next_flash   = flash;
        next_rdata   = cpu_rdata;
        next_dq_out  = flash_dq_out;
        next_dq_oe_n = flash_dq_oe_n;
        next_rdy_n   = 1'b1;
        if (state != ST_IDLE && !cs) begin
            next_state      = ST_IDLE;
            next_flash      = PINS_IDLE;
            // address kept while strobe rises
            // an aborted write still gets a clean rising edge on a steady address
            next_flash.addr = flash.addr;
            next_dq_oe_n    = 1'b1;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (!cpu_req.ads_n && cs) begin
                        next_state = ST_ANTIC;
                        next_flash.addr = cpu_req.addr[FLASH_AW-1:0];
                        next_flash.ce_n = cpu_req.be_n;
                        next_dq_out     = cpu_wdata;
                    end
                end
                ST_ANTIC: begin
                    if (!cpu_req.wr) begin
                        next_state      = ST_RD_GATE;
                        next_flash.oe_n = 1'b0;
                    end else begin
                        next_state      = ST_WR_STB;
                        next_flash.we_n = 1'b0;
                        next_dq_oe_n    = 1'b0;
                    end
                end
                ST_RD_GATE: begin
                    next_state = ST_RD_RDY;
                    next_rdy_n = 1'b0;
                    next_rdata = flash_dq_in;
                end
                ST_RD_RDY: begin
                    next_state = ST_IDLE;
                    next_flash = PINS_IDLE;
                end
                ST_WR_STB: begin
                    next_state = ST_WR_HOLD;
                end
                ST_WR_HOLD: begin
                    next_state      = ST_WR_RDY;
                    next_flash.we_n = 1'b1;
                    next_rdy_n      = 1'b0;
                end
                ST_WR_RDY: begin
                    // data held past the rising strobe
                    next_state   = ST_IDLE;
                    next_flash   = PINS_IDLE;
                    next_dq_oe_n = 1'b1;
                end
                default: begin
                    next_state   = ST_IDLE;
                    next_flash   = PINS_IDLE;
                    next_dq_oe_n = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state             <= ST_IDLE;
            flash             <= PINS_IDLE;
            cpu_rdata         <= DATA_ZERO;
            flash_dq_out      <= DATA_ZERO;
            flash_dq_oe_n     <= 1'b1;
            cpu_rdy_n         <= 1'b1;
            powerdown_reset_n <= 1'b0;
        end else if (clk_en) begin
            state             <= next_state;
            flash             <= next_flash;
            cpu_rdata         <= next_rdata;
            flash_dq_out      <= next_dq_out;
            flash_dq_oe_n     <= next_dq_oe_n;
            cpu_rdy_n         <= next_rdy_n;
            // pin held low through system reset protects the array
            powerdown_reset_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // timing checks assume no clock-enable stall inside a cycle
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n || !clk_en);

    AST_GATE_ONLY_READ: assert property (
        $fell(flash.oe_n) |-> $past(state) == ST_ANTIC && !$past(cpu_req.wr))
        else $error("output gate asserted on a write");
    AST_STROBE_ONLY_WRITE: assert property (
        $fell(flash.we_n) |-> $past(state) == ST_ANTIC && $past(cpu_req.wr) && !flash_dq_oe_n)
        else $error("write strobe without a write");
    AST_HOLD_TO_EDGE: assert property (
        !flash.we_n |=> $stable(flash.addr) && $stable(flash_dq_out))
        else $error("address or data moved under write strobe");
    AST_LANE_SELECT: assert property (
        state == ST_IDLE && !cpu_req.ads_n && cs |=> flash.ce_n == $past(cpu_req.be_n))
        else $error("lane selects do not follow byte enables");
    AST_WORD_ADDR: assert property (
        state == ST_IDLE && !cpu_req.ads_n && cs
        |=> flash.addr == $past(cpu_req.addr[FLASH_AW-1:0]))
        else $error("flash address not word address bits");
    AST_ABORT_IDLE: assert property (
        state != ST_IDLE && !cs
        |=> state == ST_IDLE && flash.ce_n == LANES_OFF && flash.oe_n && flash.we_n
            && cpu_rdy_n && $stable(flash.addr))
        else $error("lost select did not return to idle");
    AST_READ_SEQ: assert property (
        state == ST_RD_GATE && cs
        |=> !cpu_rdy_n && !flash.oe_n ##1 cpu_rdy_n && flash.oe_n && flash.ce_n == LANES_OFF)
        else $error("read ready or release out of step");
    AST_WRITE_SEQ: assert property (
        state == ST_ANTIC && cs && cpu_req.wr ##1 cs ##1 cs
        |=> flash.we_n && !cpu_rdy_n && $past(flash.we_n, 1) == 1'b0
            && $past(flash.we_n, 2) == 1'b0)
        else $error("write strobe width or ready wrong");
    AST_WRITE_RDY_ONE: assert property (
        $fell(cpu_rdy_n) && state == ST_WR_RDY |=> cpu_rdy_n && flash_dq_oe_n)
        else $error("write ready not one clock");
    AST_NO_OVERLAP: assert property (
        flash.oe_n || flash.we_n)
        else $error("gate and strobe asserted together");
    AST_IDLE_QUIET: assert property (
        flash.ce_n == LANES_OFF |-> flash.oe_n && flash.we_n)
        else $error("gate or strobe active while deselected");
    // driving the data lines under an open output gate would fight the devices
    AST_DATA_DRIVE: assert property (
        !flash_dq_oe_n |-> flash.oe_n)
        else $error("data driven while output gate open");

    COV_READ: cover property (state == ST_RD_RDY ##1 state == ST_IDLE);
    COV_WRITE: cover property (state == ST_WR_RDY ##1 state == ST_IDLE);
    COV_ABORT: cover property (state == ST_WR_STB && !cs);
    COV_BACK2BACK: cover property (state == ST_RD_RDY ##1 state == ST_ANTIC);

endmodule

// ---- dv/bfb_flash_model.sv ----
// behavioural bank of four byte-wide flash devices
module bfb_flash_model
    import bfb_pkg::*;
(
    input  wire bfb_pkg::bfb_pins_t         flash,
    input  wire logic [bfb_pkg::DATA_W-1:0] dq_wr,
    input  wire logic                       dq_oe_n,
    input  wire logic                       powerdown_reset_n,
    output logic      [bfb_pkg::DATA_W-1:0] dq_rd
);
    logic [7:0] mem [bfb_pkg::LANES][256];

    initial begin
        foreach (mem[l, a]) mem[l][a] = 8'hff;
    end

    // power-down low blocks the write; no automation to reset here
    always @(posedge flash.we_n) begin
        for (int l = 0; l < LANES; l++) begin
            if (!flash.ce_n[l] && !dq_oe_n && powerdown_reset_n) begin
                mem[l][flash.addr[7:0]] = dq_wr[8*l+:8];
            end
        end
    end

    // array data only when gated, selected and awake, inverted array data otherwise
    // a released lane shows the inverted byte so a stale sample cannot match
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            if (!flash.ce_n[l] && !flash.oe_n && powerdown_reset_n) begin
                dq_rd[8*l+:8] = mem[l][flash.addr[7:0]];
            end else begin
                dq_rd[8*l+:8] = ~mem[l][flash.addr[7:0]];
            end
        end
    end
endmodule

// ---- dv/tb_byte_flash_bank_interface.sv ----
// testbench for the flash bank bus glue
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_byte_flash_bank_interface;
    import bfb_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk_sys = 1'b0;
    logic                rst_n   = 1'b0;
    logic                clk_en  = 1'b1;
    bfb_req_t            req     = '{ads_n: 1'b1, wr: 1'b0, addr: 30'h0, be_n: 4'hf};
    logic [DATA_W-1:0]   wdata   = 32'h0;
    logic [DATA_W-1:0]   rdata;
    logic                rdy_n;
    bfb_pins_t           flash;
    logic [DATA_W-1:0]   dq_in;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe_n;
    logic                pd_n;
    logic [DATA_W-1:0]   rd;
    logic [LANES-1:0]    ce;
    int                  lat;
    int                  errors = 0;
    int                  num_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    bfb_ctrl bfb_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cpu_req(req),
        .cpu_wdata(wdata), .cpu_rdata(rdata), .cpu_rdy_n(rdy_n), .flash(flash),
        .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n),
        .powerdown_reset_n(pd_n));
    bfb_flash_model bfb_flash_model_i (.flash(flash), .dq_wr(dq_out), .dq_oe_n(dq_oe_n),
        .powerdown_reset_n(pd_n), .dq_rd(dq_in));

    task automatic step;
        @(posedge clk_sys);
        #2;
    endtask

    // one bus cycle: count edges after the one taking ads_n until ready, ten means none
    task automatic bus(input logic w, input logic [29:0] a, input logic [3:0] be,
                       input logic [31:0] wd);
        step;
        req = '{ads_n: 1'b0, wr: w, addr: a, be_n: be};
        wdata = wd;
        step;
        req.ads_n = 1'b1;
        lat = 0;
        while (rdy_n !== 1'b0 && lat < 10) begin
            step;
            lat++;
        end
        rd = rdata;
        ce = flash.ce_n;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_write_read;
        bus(1'b1, 30'h5, 4'h0, 32'h1234abcd);
        `CHK("wr lat", 3, lat)
        bus(1'b1, 30'h6, 4'h0, 32'h0badf00d);
        bus(1'b0, 30'h5, 4'h0, 32'h0);
        `CHK("rd lat", 2, lat)
        `CHK("rd 5", 32'h1234abcd, rd)
        bus(1'b0, 30'h6, 4'h0, 32'h0);
        `CHK("rd 6", 32'h0badf00d, rd)
        $display("test_write_read done");
    endtask

    task automatic test_lanes;
        bus(1'b1, 30'h5, 4'he, 32'hffffff77);
        `CHK("wr ce", 4'he, ce)
        bus(1'b0, 30'h5, 4'h0, 32'h0);
        `CHK("lane rd", 32'h1234ab77, rd)
        $display("test_lanes done");
    endtask

    // a clock-enable stall must freeze the read, not shorten it
    task automatic test_stall;
        step;
        req = '{ads_n: 1'b0, wr: 1'b0, addr: 30'h5, be_n: 4'h0};
        step;
        req.ads_n = 1'b1;
        clk_en = 1'b0;
        repeat (3) step;
        `CHK("stall oe", 1'b1, flash.oe_n)
        clk_en = 1'b1;
        step;
        `CHK("stall gate", 1'b0, flash.oe_n)
        step;
        `CHK("stall rdy", 1'b0, rdy_n)
        `CHK("stall rd", 32'h1234ab77, rdata)
        step;
        `CHK("stall end", 1'b1, rdy_n)
        $display("test_stall done");
    endtask

    // a miss and a mid-cycle deselect must both end without ready
    task automatic test_abort;
        bus(1'b0, 30'h100005, 4'h0, 32'h0);
        `CHK("miss", 10, lat)
        `CHK("miss ce", 4'hf, flash.ce_n)
        step;
        req = '{ads_n: 1'b0, wr: 1'b0, addr: 30'h5, be_n: 4'h0};
        step;
        req.ads_n = 1'b1;
        step;
        req.be_n = 4'hf;
        step;
        `CHK("abort rdy", 1'b1, rdy_n)
        `CHK("abort oe", 1'b1, flash.oe_n)
        `CHK("abort ce", 4'hf, flash.ce_n)
        repeat (2) begin
            step;
            `CHK("abort rdy late", 1'b1, rdy_n)
        end
        step;
        req = '{ads_n: 1'b0, wr: 1'b1, addr: 30'h7, be_n: 4'h0};
        wdata = 32'h5a5a5a5a;
        step;
        req.ads_n = 1'b1;
        step;
        `CHK("wabort strobe", 1'b0, flash.we_n)
        req.be_n = 4'hf;
        step;
        `CHK("wabort we", 1'b1, flash.we_n)
        `CHK("wabort addr", 20'h00007, flash.addr)
        `CHK("wabort rdy", 1'b1, rdy_n)
        $display("test_abort done");
    endtask

    task automatic test_reset;
        rst_n = 1'b0;
        step;
        step;
        `CHK("pd low", 1'b0, pd_n)
        `CHK("we idle", 1'b1, flash.we_n)
        rst_n = 1'b1;
        step;
        `CHK("pd high", 1'b1, pd_n)
        bus(1'b0, 30'h6, 4'h0, 32'h0);
        `CHK("wake rd", 32'h0badf00d, rd)
        $display("test_reset done");
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (10) step;
        rst_n = 1'b1;
        test_write_read;
        test_lanes;
        test_stall;
        test_abort;
        test_reset;
        finish_test;
    end

    // the tests need well under 200 cycles
    initial begin
        repeat (2000) @(posedge clk_sys);
        errors++;
        finish_test;
    end
endmodule
